//--- hw/xfer_consts.svh
// constants for the accumulator-to-control-register transfer block
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH

// --------------------------------------------------------------
// opcodes
// --------------------------------------------------------------
`define OPC_PORT_OUT 10'h029
`define OPC_POINTER 10'h01a
`define OPC_PINFUNC_ZERO 10'h228
`define OPC_PINFUNC_ONE 10'h229
`define OPC_PINFUNC_TWO 10'h22a
`define OPC_IRQ_CTL_ONE 10'h217
`define OPC_WAKE_CTL_ZERO 10'h21b
`define OPC_WAKE_CTL_ONE 10'h214

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_PORT_PTR 8'h04
`define REG_PINFUNC 8'h08
`define REG_IRQ_WAKE 8'h0c
`define REG_EXEC_CNT 8'h10

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define CTRL_EXEC_EN_BIT 0
`define CTRL_RESET 1'h1
`define NIB_RESET 4'h0
`define PORT_RESET 3'h0
`define PTR_RESET 8'h00
`define CNT_RESET 8'h00

`endif

//--- hw/xfer_pkg.sv
// types for the accumulator-to-control-register transfer block
package xfer_pkg;
    typedef enum logic [3:0] {
        OP_NONE,
        OP_PORT_OUT,
        OP_POINTER,
        OP_PINFUNC_ZERO,
        OP_PINFUNC_ONE,
        OP_PINFUNC_TWO,
        OP_IRQ_CTL_ONE,
        OP_WAKE_CTL_ZERO,
        OP_WAKE_CTL_ONE
    } xfer_op_t;
endpackage

//--- hw/xfer_decode.sv
// opcode decoder for the transfer instructions
`timescale 1ns/1ns
`include "xfer_consts.svh"
module xfer_decode (
    // instruction
    input wire logic [9:0] instr_word,
    input wire logic instr_valid,
    // decoded operation
    output xfer_pkg::xfer_op_t op
);
    function automatic xfer_pkg::xfer_op_t decode_op(input logic [9:0] w);
        case (w)
            `OPC_PORT_OUT: decode_op = xfer_pkg::OP_PORT_OUT;
            `OPC_POINTER: decode_op = xfer_pkg::OP_POINTER;
            `OPC_PINFUNC_ZERO: decode_op = xfer_pkg::OP_PINFUNC_ZERO;
            `OPC_PINFUNC_ONE: decode_op = xfer_pkg::OP_PINFUNC_ONE;
            `OPC_PINFUNC_TWO: decode_op = xfer_pkg::OP_PINFUNC_TWO;
            `OPC_IRQ_CTL_ONE: decode_op = xfer_pkg::OP_IRQ_CTL_ONE;
            `OPC_WAKE_CTL_ZERO: decode_op = xfer_pkg::OP_WAKE_CTL_ZERO;
            `OPC_WAKE_CTL_ONE: decode_op = xfer_pkg::OP_WAKE_CTL_ONE;
            default: decode_op = xfer_pkg::OP_NONE;
        endcase
    endfunction

    always_comb begin
        op = instr_valid ? decode_op(instr_word) : xfer_pkg::OP_NONE;
    end
endmodule

//--- hw/acc_xfer_top.sv
// accumulator-to-control-register transfer execute logic with apb view
`timescale 1ns/1ns
`include "xfer_consts.svh"
// Operation
// - opcode 0x029 copies acc bits 2..0 to the port output, one cycle.
// - pointer load puts B in pointer bits 7..4, acc in 3..0, one cycle.
// - opcode 0x228 copies acc to pin function control zero, one cycle.
// - opcode 0x229 copies acc to pin function control one, one cycle.
// - opcode 0x22a copies acc to pin function control two, one cycle.
// - opcode 0x217 copies acc to interrupt control one, one cycle.
// - opcode 0x21b copies acc to wakeup control zero, one cycle.
// - opcode 0x214 copies acc to wakeup control one, one cycle.
module acc_xfer_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction stream and core registers
    input wire logic [9:0] instr_word,
    input wire logic instr_valid,
    input wire logic [3:0] acc_val,
    input wire logic [3:0] breg_val,
    // core side effects
    output logic carry_flag_we,
    output logic skip_next,
    output logic acc_we,
    output logic breg_we,
    // destination registers
    output logic [2:0] port_out_reg,
    output logic [7:0] pointer_reg,
    output logic [3:0] pinfunc_ctl_zero,
    output logic [3:0] pinfunc_ctl_one,
    output logic [3:0] pinfunc_ctl_two,
    output logic [3:0] irq_ctl_one,
    output logic [3:0] wake_ctl_zero,
    output logic [3:0] wake_ctl_one
);
    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    xfer_pkg::xfer_op_t op;
    logic exec_en_ff;
    logic nxt_exec_en;
    logic do_exec;

    xfer_decode u_decode (
        .instr_word(instr_word),
        .instr_valid(instr_valid),
        .op(op)
    );

    assign do_exec = exec_en_ff && (op != xfer_pkg::OP_NONE);

    // --------------------------------------------------------------
    // destination registers
    // --------------------------------------------------------------
    logic [2:0] port_ff, nxt_port;
    logic [7:0] ptr_ff, nxt_ptr;
    logic [3:0] fr0_ff, nxt_fr0;
    logic [3:0] fr1_ff, nxt_fr1;
    logic [3:0] fr2_ff, nxt_fr2;
    logic [3:0] irq1_ff, nxt_irq1;
    logic [3:0] wk0_ff, nxt_wk0;
    logic [3:0] wk1_ff, nxt_wk1;
    logic [7:0] cnt_ff, nxt_cnt;

    always_comb begin
        nxt_port = port_ff;
        nxt_ptr = ptr_ff;
        nxt_fr0 = fr0_ff;
        nxt_fr1 = fr1_ff;
        nxt_fr2 = fr2_ff;
        nxt_irq1 = irq1_ff;
        nxt_wk0 = wk0_ff;
        nxt_wk1 = wk1_ff;
        nxt_cnt = do_exec ? cnt_ff + 8'h01 : cnt_ff;
        if (exec_en_ff) begin
            case (op)
                xfer_pkg::OP_PORT_OUT: nxt_port = acc_val[2:0];
                xfer_pkg::OP_POINTER: nxt_ptr = {breg_val, acc_val};
                xfer_pkg::OP_PINFUNC_ZERO: nxt_fr0 = acc_val;
                xfer_pkg::OP_PINFUNC_ONE: nxt_fr1 = acc_val;
                xfer_pkg::OP_PINFUNC_TWO: nxt_fr2 = acc_val;
                xfer_pkg::OP_IRQ_CTL_ONE: nxt_irq1 = acc_val;
                xfer_pkg::OP_WAKE_CTL_ZERO: nxt_wk0 = acc_val;
                xfer_pkg::OP_WAKE_CTL_ONE: nxt_wk1 = acc_val;
                default: nxt_port = port_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_ff <= `PORT_RESET;
            ptr_ff <= `PTR_RESET;
            fr0_ff <= `NIB_RESET;
            fr1_ff <= `NIB_RESET;
            fr2_ff <= `NIB_RESET;
            irq1_ff <= `NIB_RESET;
            wk0_ff <= `NIB_RESET;
            wk1_ff <= `NIB_RESET;
            cnt_ff <= `CNT_RESET;
        end else begin
            port_ff <= nxt_port;
            ptr_ff <= nxt_ptr;
            fr0_ff <= nxt_fr0;
            fr1_ff <= nxt_fr1;
            fr2_ff <= nxt_fr2;
            irq1_ff <= nxt_irq1;
            wk0_ff <= nxt_wk0;
            wk1_ff <= nxt_wk1;
            cnt_ff <= nxt_cnt;
        end
    end

    assign port_out_reg = port_ff;
    assign pointer_reg = ptr_ff;
    assign pinfunc_ctl_zero = fr0_ff;
    assign pinfunc_ctl_one = fr1_ff;
    assign pinfunc_ctl_two = fr2_ff;
    assign irq_ctl_one = irq1_ff;
    assign wake_ctl_zero = wk0_ff;
    assign wake_ctl_one = wk1_ff;

    // core side effects stay off for this group
    assign carry_flag_we = 1'b0;
    assign skip_next = 1'b0;
    assign acc_we = 1'b0;
    assign breg_we = 1'b0;

    // --------------------------------------------------------------
    // apb slave
    // --------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic addr_ok;
    logic [31:0] rd_ff, nxt_rd;
    logic err_ff, nxt_err;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign pready = access_ph;
    assign prdata = rd_ff;
    assign pslverr = access_ph && err_ff;

    always_comb begin
        nxt_rd = rd_ff;
        nxt_err = err_ff;
        nxt_exec_en = exec_en_ff;
        addr_ok = 1'b1;
        case (paddr)
            `REG_CTRL: nxt_rd = {31'h0, exec_en_ff};
            `REG_PORT_PTR: nxt_rd = {16'h0, ptr_ff, 5'h0, port_ff};
            `REG_PINFUNC: nxt_rd = {20'h0, fr2_ff, fr1_ff, fr0_ff};
            `REG_IRQ_WAKE: nxt_rd = {20'h0, wk1_ff, wk0_ff, irq1_ff};
            `REG_EXEC_CNT: nxt_rd = {24'h0, cnt_ff};
            default: begin
                nxt_rd = 32'h0;
                addr_ok = 1'b0;
            end
        endcase
        if (setup_ph) begin
            nxt_err = !addr_ok;
            if (pwrite) begin
                nxt_rd = 32'h0;
            end
        end else begin
            nxt_rd = rd_ff;
        end
        if (access_ph && pwrite && paddr == `REG_CTRL) begin
            nxt_exec_en = pwdata[`CTRL_EXEC_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= 32'h0;
            err_ff <= 1'b0;
            exec_en_ff <= `CTRL_RESET;
        end else begin
            rd_ff <= nxt_rd;
            err_ff <= nxt_err;
            exec_en_ff <= nxt_exec_en;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    port_copy_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_PORT_OUT
        |=> port_out_reg == $past(acc_val[2:0]))
        else $error("port output register not loaded");
    pointer_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_POINTER
        |=> pointer_reg == {$past(breg_val), $past(acc_val)})
        else $error("pointer register not loaded from b and a");
    pinfunc0_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_PINFUNC_ZERO
        |=> pinfunc_ctl_zero == $past(acc_val) && $stable(pinfunc_ctl_one))
        else $error("pin function zero not loaded");
    pinfunc1_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_PINFUNC_ONE
        |=> pinfunc_ctl_one == $past(acc_val) && $stable(pinfunc_ctl_two))
        else $error("pin function one not loaded");
    pinfunc2_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_PINFUNC_TWO
        |=> pinfunc_ctl_two == $past(acc_val) && $stable(pinfunc_ctl_zero))
        else $error("pin function two not loaded");
    irq1_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_IRQ_CTL_ONE
        |=> irq_ctl_one == $past(acc_val) && $stable(wake_ctl_zero))
        else $error("interrupt control one not loaded");
    wake0_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_WAKE_CTL_ZERO
        |=> wake_ctl_zero == $past(acc_val) && $stable(wake_ctl_one))
        else $error("wakeup control zero not loaded");
    wake1_load_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        exec_en_ff && instr_valid && instr_word == `OPC_WAKE_CTL_ONE
        |=> wake_ctl_one == $past(acc_val) && $stable(irq_ctl_one))
        else $error("wakeup control one not loaded");
    no_side_effect_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        do_exec |-> !carry_flag_we && !skip_next && !acc_we && !breg_we)
        else $error("transfer disturbed carry, skip, a or b");
    idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !instr_valid |=> $stable(pointer_reg) && $stable(port_out_reg))
        else $error("destination changed without an instruction");
endmodule

//--- bench/testbench.sv
// self-checking bench for the accumulator transfer execute block
`timescale 1ns/1ns
`include "xfer_consts.svh"
module testbench;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] instr_word = 10'h000;
    logic instr_valid = 1'b0;
    logic [3:0] acc_val = 4'h0;
    logic [3:0] breg_val = 4'h0;
    logic carry_flag_we, skip_next, acc_we, breg_we;
    logic [2:0] port_out_reg;
    logic [7:0] pointer_reg;
    logic [3:0] pinfunc_ctl_zero, pinfunc_ctl_one, pinfunc_ctl_two;
    logic [3:0] irq_ctl_one, wake_ctl_zero, wake_ctl_one;
    int fail_count = 0;
    int num_checks = 0;
    logic [9:0] ops [8];
    logic [31:0] rd;
    logic er;
    logic [63:0] s;
    logic [3:0] side_fx;

    always #20 pclk = ~pclk;

    assign side_fx = {carry_flag_we, skip_next, acc_we, breg_we};

    acc_xfer_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_word(instr_word),
        .instr_valid(instr_valid), .acc_val(acc_val),
        .breg_val(breg_val), .carry_flag_we(carry_flag_we),
        .skip_next(skip_next), .acc_we(acc_we), .breg_we(breg_we),
        .port_out_reg(port_out_reg), .pointer_reg(pointer_reg),
        .pinfunc_ctl_zero(pinfunc_ctl_zero),
        .pinfunc_ctl_one(pinfunc_ctl_one),
        .pinfunc_ctl_two(pinfunc_ctl_two), .irq_ctl_one(irq_ctl_one),
        .wake_ctl_zero(wake_ctl_zero), .wake_ctl_one(wake_ctl_one));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function logic [7:0] dest(int i);
        case (i)
            0: return {5'h00, port_out_reg};
            1: return pointer_reg;
            2: return {4'h0, pinfunc_ctl_zero};
            3: return {4'h0, pinfunc_ctl_one};
            4: return {4'h0, pinfunc_ctl_two};
            5: return {4'h0, irq_ctl_one};
            6: return {4'h0, wake_ctl_zero};
            default: return {4'h0, wake_ctl_one};
        endcase
    endfunction

    function logic [63:0] snap();
        logic [63:0] v;
        for (int i = 0; i < 8; i++) v[i*8 +: 8] = dest(i);
        return v;
    endfunction

    function logic [7:0] want(int i);
        logic [3:0] a;
        a = 4'(i + 3);
        if (i == 0) return {5'h00, a[2:0]};
        if (i == 1) return {4'(6 - i), a};
        return {4'h0, a};
    endfunction

    task check(string name, logic [63:0] seen, logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task issue(logic [9:0] op, logic v, logic [3:0] a, logic [3:0] b);
        @(posedge pclk);
        instr_word <= op;
        instr_valid <= v;
        acc_val <= a;
        breg_val <= b;
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge pclk);
        fail_count++;
        complete_run();
    end

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        ops = '{`OPC_PORT_OUT, `OPC_POINTER, `OPC_PINFUNC_ZERO,
            `OPC_PINFUNC_ONE, `OPC_PINFUNC_TWO, `OPC_IRQ_CTL_ONE,
            `OPC_WAKE_CTL_ZERO, `OPC_WAKE_CTL_ONE};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        #1 check("reset dests", snap(), 64'h0);
        for (int i = 0; i <= 8; i++) begin
            @(posedge pclk);
            if (i < 8) begin
                instr_word <= ops[i];
                instr_valid <= 1'b1;
                acc_val <= 4'(i + 3);
                breg_val <= 4'(6 - i);
            end else begin
                instr_valid <= 1'b0;
            end
            #1;
            case (i)
                1: check("port", dest(0), want(0));
                2: check("pointer", dest(1), want(1));
                3: check("pinfunc0", dest(2), want(2));
                4: check("pinfunc1", dest(3), want(3));
                5: check("pinfunc2", dest(4), want(4));
                6: check("irq1", dest(5), want(5));
                7: check("wake0", dest(6), want(6));
                8: check("wake1", dest(7), want(7));
                default: ;
            endcase
            if (i > 0) begin
                check("side", side_fx, 0);
            end
        end
        s = snap();
        issue(10'h3ff, 1'b1, 4'hf, 4'hf);
        issue(`OPC_PINFUNC_ZERO, 1'b0, 4'hf, 4'hf);
        @(posedge pclk);
        #1 check("refused", snap(), s);
        apb(1'b1, `REG_CTRL, 32'h0);
        issue(`OPC_PORT_OUT, 1'b1, 4'he, 4'h0);
        issue(`OPC_PORT_OUT, 1'b0, 4'he, 4'h0);
        #1 check("disabled", snap(), s);
        apb(1'b1, `REG_CTRL, 32'h1);
        apb(1'b0, `REG_CTRL, 32'h0);
        check("ctrl", rd, 32'h1);
        issue(`OPC_PORT_OUT, 1'b1, 4'he, 4'h0);
        issue(`OPC_PORT_OUT, 1'b0, 4'he, 4'h0);
        #1 check("port", port_out_reg, 3'h6);
        apb(1'b0, `REG_PORT_PTR, 32'h0);
        check("port ptr", rd, 32'h0000_5406);
        apb(1'b0, `REG_PINFUNC, 32'h0);
        check("pinfunc", rd, 32'h0000_0765);
        apb(1'b0, `REG_IRQ_WAKE, 32'h0);
        check("irq wake", rd, 32'h0000_0a98);
        apb(1'b0, `REG_EXEC_CNT, 32'h0);
        check("count", rd, 32'h0000_0009);
        apb(1'b1, `REG_PORT_PTR, 32'hffff_ffff);
        check("ro err", er, 1'b0);
        apb(1'b0, `REG_PORT_PTR, 32'h0);
        check("ro keep", rd, 32'h0000_5406);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {er, rd}, 33'h1_0000_0000);
        complete_run();
    end
endmodule
